/* File: perf_event_qualifier_params.svh */
// Operation
// - power event accumulates every cycle the processor is not stopped.
// - power mask bit 0 qualifies all active time, halt and throttle included.
// - delivery-switch event counts each trace cache to microcode ROM switch, mask bit 0.
// - queue-write event counts each valid micro-op whose source bit is enabled.
// - software sets source bits: 0 build mode, 1 deliver mode, 2 ROM.
// - allocator stall event counts occurrences or duration of stalls.
// - stall mask bit 5 qualifies stalls from store buffer exhaustion.
// - allocator stall event may be absent on some models.
// - combine buffer event counts only operations whose mask bits are enabled.
// - combine buffer mask bit 0 qualifies evictions of every cause.
// - combine buffer mask bit 1 qualifies evictions for lack of free buffer.
`ifndef PERF_EVENT_QUALIFIER_PARAMS_SVH
`define PERF_EVENT_QUALIFIER_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_EVSEL   8'h00
`define OFS_CFG     8'h04
`define OFS_COUNT   8'h08
`define OFS_STATUS  8'h0C

// ----------------------------------------
// field positions
// ----------------------------------------
`define SEL_HI      31
`define SEL_LO      25
`define MASK_HI     24
`define MASK_LO     9
`define GRP_HI      15
`define GRP_LO      13
`define CFG_ENABLE  12
`define CFG_EDGE    24
`define ST_OVF      0
`define ST_STALL_OK 1
`define ST_HIT      2

// ----------------------------------------
// reset values
// ----------------------------------------
`define EVSEL_RST   32'h0000_0000
`define CFG_RST     32'h0000_0000
`define COUNT_RST   32'h0000_0000

// ----------------------------------------
// event codes and groups
// ----------------------------------------
`define SEL_POWER   7'h05
`define SEL_SWITCH  7'h05
`define SEL_QWRITE  7'h09
`define SEL_STALL   7'h01
`define SEL_COMBINE 7'h05
`define GRP_POWER   3'h6
`define GRP_SWITCH  3'h0
`define GRP_QWRITE  3'h0
`define GRP_STALL   3'h1
`define GRP_COMBINE 3'h5

// ----------------------------------------
// mask bit positions within the 16-bit mask
// ----------------------------------------
`define MB_RUNNING   0
`define MB_ROM_XFER  0
`define MB_BUILD     0
`define MB_DELIVER   1
`define MB_ROM       2
`define MB_STORE_BUF 5
`define MB_ANY_EVICT 0
`define MB_FULL_EVICT 1

// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: perf_event_pkg.sv */
package perf_event_pkg;

  typedef enum logic [5:0]
  {
    EV_NONE    = 6'b000001,
    EV_POWER   = 6'b000010,
    EV_SWITCH  = 6'b000100,
    EV_QWRITE  = 6'b001000,
    EV_STALL   = 6'b010000,
    EV_COMBINE = 6'b100000
  } event_id_type;

endpackage

/* File: event_counter.sv */
`timescale 1ns/1ns
`include "perf_event_qualifier_params.svh"

module event_counter #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // increment and load
  input  wire logic [1:0]       inc,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_data,
  // state
  output logic      [WIDTH-1:0] value,
  output logic                  overflow
);

  logic [WIDTH:0]   sum;
  logic [WIDTH-1:0] next_value;
  logic             next_overflow;

  // a software load wins over a same-cycle increment
  always_comb
  begin
    sum           = {1'b0, value} + {{(WIDTH - 1){1'b0}}, inc};
    next_value    = load ? load_data : sum[WIDTH-1:0];
    next_overflow = ~load & sum[WIDTH];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      value    <= WIDTH'(`COUNT_RST);
      overflow <= 1'b0;
    end
    else
    begin
      value    <= next_value;
      overflow <= next_overflow;
    end
  end

endmodule

/* File: event_qualifier.sv */
`timescale 1ns/1ns
`include "perf_event_qualifier_params.svh"

module event_qualifier #(
  parameter bit STALL_SUPPORTED = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // configuration
  input  wire logic        enable,
  input  wire logic        edge_mode,
  input  wire logic [6:0]  event_select,
  input  wire logic [15:0] event_mask,
  input  wire logic [2:0]  select_group,
  // pipeline event sources
  input  wire logic        not_stopped,
  input  wire logic        delivery_switch_event,
  input  wire logic        src_build_mode,
  input  wire logic        src_deliver_mode,
  input  wire logic        src_rom,
  input  wire logic        store_buf_exhausted,
  input  wire logic        evict_any,
  input  wire logic        evict_no_free,
  // result
  output logic      [1:0]  inc,
  output logic             hit
);

  perf_event_pkg::event_id_type id;
  logic [1:0] raw;
  logic       raw_hit;
  logic       prev_hit;
  logic [1:0] next_inc;

  function automatic logic [1:0] ones3(input logic [2:0] v);
    ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  always_comb
  begin
    unique case ({event_select, select_group})
      {`SEL_POWER,   `GRP_POWER}:   id = perf_event_pkg::EV_POWER;
      {`SEL_SWITCH,  `GRP_SWITCH}:  id = perf_event_pkg::EV_SWITCH;
      {`SEL_QWRITE,  `GRP_QWRITE}:  id = perf_event_pkg::EV_QWRITE;
      {`SEL_STALL,   `GRP_STALL}:   id = perf_event_pkg::EV_STALL;
      {`SEL_COMBINE, `GRP_COMBINE}: id = perf_event_pkg::EV_COMBINE;
      default:                      id = perf_event_pkg::EV_NONE;
    endcase
  end

  always_comb
  begin
    raw = 2'h0;
    unique case (id)
      perf_event_pkg::EV_POWER:
        raw = {1'b0, event_mask[`MB_RUNNING] & not_stopped};
      perf_event_pkg::EV_SWITCH:
        raw = {1'b0, event_mask[`MB_ROM_XFER] & delivery_switch_event};
      perf_event_pkg::EV_QWRITE:
        raw = ones3({event_mask[`MB_ROM] & src_rom,
                     event_mask[`MB_DELIVER] & src_deliver_mode,
                     event_mask[`MB_BUILD] & src_build_mode});
      perf_event_pkg::EV_STALL:
        raw = {1'b0, STALL_SUPPORTED & event_mask[`MB_STORE_BUF]
                     & store_buf_exhausted};
      perf_event_pkg::EV_COMBINE:
        raw = {1'b0, (event_mask[`MB_ANY_EVICT] & evict_any)
                     | (event_mask[`MB_FULL_EVICT] & evict_no_free)};
      perf_event_pkg::EV_NONE:
        raw = 2'h0;
    endcase
    raw_hit = enable & (raw != 2'h0);
    // edge mode turns a duration count into an occurrence count
    if (edge_mode)
      next_inc = {1'b0, raw_hit & ~prev_hit};
    else
      next_inc = enable ? raw : 2'h0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      inc      <= 2'h0;
      hit      <= 1'b0;
      prev_hit <= 1'b0;
    end
    else
    begin
      inc      <= next_inc;
      hit      <= raw_hit;
      prev_hit <= raw_hit;
    end
  end

endmodule

/* File: perf_event_qualifier.sv */
`timescale 1ns/1ns
`include "perf_event_qualifier_params.svh"

module perf_event_qualifier #(
  parameter bit STALL_SUPPORTED = 1'b1,
  parameter int COUNT_WIDTH     = 32
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  // write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // pipeline event sources, same clock
  input  wire logic        NOT_STOPPED,
  input  wire logic        DELIVERY_SWITCH,
  input  wire logic        SRC_BUILD_MODE,
  input  wire logic        SRC_DELIVER_MODE,
  input  wire logic        SRC_ROM,
  input  wire logic        STORE_BUF_EXHAUSTED,
  input  wire logic        EVICT_ANY,
  input  wire logic        EVICT_NO_FREE,
  // counter state
  output logic             OVERFLOW_FLAG
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [31:0]            event_selection_control;
  logic [31:0]            counter_config_control;
  logic [31:0]            next_evsel;
  logic [31:0]            next_cfg;
  logic                   next_overflow_flag;

  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic [7:0]             next_aw_addr;
  logic [31:0]            next_w_data;
  logic [3:0]             next_w_strb;
  logic                   next_awready;
  logic                   next_wready;
  logic                   next_bvalid;
  logic [1:0]             next_bresp;
  logic                   next_arready;
  logic                   next_rvalid;
  logic [31:0]            next_rdata;
  logic [1:0]             next_rresp;

  logic                   wr_fire;
  logic                   wr_mapped;
  logic                   count_load;
  logic [31:0]            status_word;
  logic [31:0]            load_word;

  logic [1:0]             inc;
  logic                   hit;
  logic [COUNT_WIDTH-1:0] count_value;
  logic                   count_wrap;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `OFS_EVSEL) || (addr == `OFS_CFG)
                || (addr == `OFS_COUNT) || (addr == `OFS_STATUS);
  endfunction

  // ----------------------------------------
  // event qualification and counting
  // ----------------------------------------
  event_qualifier #(
    .STALL_SUPPORTED (STALL_SUPPORTED)
  ) u_qualifier (
    .clk                   (CLK_SYS),
    .arst_n                (ARST_N),
    .enable                (counter_config_control[`CFG_ENABLE]),
    .edge_mode             (counter_config_control[`CFG_EDGE]),
    .event_select          (event_selection_control[`SEL_HI:`SEL_LO]),
    .event_mask            (event_selection_control[`MASK_HI:`MASK_LO]),
    .select_group          (counter_config_control[`GRP_HI:`GRP_LO]),
    .not_stopped           (NOT_STOPPED),
    .delivery_switch_event (DELIVERY_SWITCH),
    .src_build_mode        (SRC_BUILD_MODE),
    .src_deliver_mode      (SRC_DELIVER_MODE),
    .src_rom               (SRC_ROM),
    .store_buf_exhausted   (STORE_BUF_EXHAUSTED),
    .evict_any             (EVICT_ANY),
    .evict_no_free         (EVICT_NO_FREE),
    .inc                   (inc),
    .hit                   (hit)
  );

  event_counter #(
    .WIDTH (COUNT_WIDTH)
  ) u_counter (
    .clk       (CLK_SYS),
    .arst_n    (ARST_N),
    .inc       (inc),
    .load      (count_load),
    .load_data (load_word[COUNT_WIDTH-1:0]),
    .value     (count_value),
    .overflow  (count_wrap)
  );

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // address and data are taken in either order; the write lands one
  // cycle after both are held, and the response follows at once
  assign wr_fire    = aw_held & w_held & ~BVALID;
  assign wr_mapped  = is_mapped(aw_addr);
  assign count_load = wr_fire & (aw_addr == `OFS_COUNT);
  assign load_word  = merge(32'(count_value), w_data, w_strb);

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = BVALID;
    next_bresp   = BRESP;
    if (AWVALID && AWREADY)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (BVALID && BREADY)
    begin
      next_bvalid = 1'b0;
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready  = ~next_w_held & ~next_bvalid;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      AWREADY <= next_awready;
      WREADY  <= next_wready;
      BVALID  <= next_bvalid;
      BRESP   <= next_bresp;
    end
  end

  // ----------------------------------------
  // control registers and sticky overflow
  // ----------------------------------------
  always_comb
  begin
    next_evsel         = event_selection_control;
    next_cfg           = counter_config_control;
    next_overflow_flag = OVERFLOW_FLAG;
    if (wr_fire && aw_addr == `OFS_EVSEL)
      next_evsel = merge(event_selection_control, w_data, w_strb);
    if (wr_fire && aw_addr == `OFS_CFG)
      next_cfg = merge(counter_config_control, w_data, w_strb);
    // write one to clear; a wrap in the same cycle keeps the flag set
    if (wr_fire && aw_addr == `OFS_STATUS && w_strb[0] && w_data[`ST_OVF])
      next_overflow_flag = 1'b0;
    if (count_wrap)
      next_overflow_flag = 1'b1;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      event_selection_control <= `EVSEL_RST;
      counter_config_control  <= `CFG_RST;
      OVERFLOW_FLAG           <= 1'b0;
    end
    else
    begin
      event_selection_control <= next_evsel;
      counter_config_control  <= next_cfg;
      OVERFLOW_FLAG           <= next_overflow_flag;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_comb
  begin
    status_word               = 32'h0000_0000;
    status_word[`ST_OVF]      = OVERFLOW_FLAG;
    status_word[`ST_STALL_OK] = STALL_SUPPORTED;
    status_word[`ST_HIT]      = hit;
  end

  // one read at a time: the address is refused while data is pending
  always_comb
  begin
    next_rvalid = RVALID;
    next_rdata  = RDATA;
    next_rresp  = RRESP;
    if (ARVALID && ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp  = is_mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (ARADDR)
        `OFS_EVSEL:  next_rdata = event_selection_control;
        `OFS_CFG:    next_rdata = counter_config_control;
        `OFS_COUNT:  next_rdata = 32'(count_value);
        `OFS_STATUS: next_rdata = status_word;
        default:     next_rdata = 32'h0000_0000;
      endcase
    end
    else if (RVALID && RREADY)
    begin
      next_rvalid = 1'b0;
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= `RESP_OKAY;
    end
    else
    begin
      ARREADY <= next_arready;
      RVALID  <= next_rvalid;
      RDATA   <= next_rdata;
      RRESP   <= next_rresp;
    end
  end

endmodule

/* File: perf_event_qualifier_assertions.sv */
`timescale 1ns/1ns
`include "perf_event_qualifier_params.svh"

module perf_event_qualifier_checker #(
  parameter bit STALL_SUPPORTED = 1'b1,
  parameter int COUNT_WIDTH     = 32
) (
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  // write channels
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  // read channels
  input wire logic [7:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // counter state
  input wire logic        OVERFLOW_FLAG
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  // ----------------------------------------
  // address of the read in flight
  // ----------------------------------------
  logic [7:0] rd_addr;
  logic [7:0] next_rd_addr;

  always_comb
  begin
    next_rd_addr = rd_addr;
    if (ARVALID && ARREADY)
    begin
      next_rd_addr = ARADDR;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      rd_addr <= 8'h00;
    else
      rd_addr <= next_rd_addr;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence write_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence

  sequence answer_after_update;
    !BVALID ##1 BVALID;
  endsequence

  a_write_answer_time: assert property (write_taken |=> answer_after_update)
    else $error("write answer not two cycles after handshake");
  a_address_closed: assert property ((AWVALID && AWREADY) |=> !AWREADY [*2])
    else $error("write address taken again before answer");
  a_write_resp_held: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped before acceptance");
  a_read_answer_prompt: assert property ((ARVALID && ARREADY) |=> RVALID)
    else $error("read answer late");
  a_read_data_held: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer changed before acceptance");
  a_read_refused: assert property (RVALID |-> !ARREADY)
    else $error("read address accepted while answer pending");
  a_unmapped_read: assert property (RVALID && rd_addr > `OFS_STATUS
    |-> RRESP == `RESP_SLVERR && RDATA == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_stall_flag_read: assert property (RVALID && rd_addr == `OFS_STATUS
    |-> RDATA[`ST_STALL_OK] == STALL_SUPPORTED)
    else $error("stall support flag wrong");
  a_flag_sticky: assert property ($fell(OVERFLOW_FLAG) |-> $rose(BVALID))
    else $error("overflow flag cleared without a write");
endmodule

bind perf_event_qualifier perf_event_qualifier_checker #(
  .STALL_SUPPORTED (STALL_SUPPORTED),
  .COUNT_WIDTH     (COUNT_WIDTH)
) checker_inst (
  .CLK_SYS       (CLK_SYS),
  .ARST_N        (ARST_N),
  .AWVALID       (AWVALID),
  .AWREADY       (AWREADY),
  .WVALID        (WVALID),
  .WREADY        (WREADY),
  .BRESP         (BRESP),
  .BVALID        (BVALID),
  .BREADY        (BREADY),
  .ARADDR        (ARADDR),
  .ARVALID       (ARVALID),
  .ARREADY       (ARREADY),
  .RDATA         (RDATA),
  .RRESP         (RRESP),
  .RVALID        (RVALID),
  .RREADY        (RREADY),
  .OVERFLOW_FLAG (OVERFLOW_FLAG)
);

/* File: event_source_model.sv */
`timescale 1ns/1ns

module event_source_model (
  // clock
  input wire logic  clk,
  // bit 0 running, 1 switch, 2..4 queue sources, 5 store stall, 6..7 evictions
  output logic [7:0] events
);
  initial events = 8'h00;

  // a stall is a level, the others one entry per cycle they are high
  task automatic emit(input logic [7:0] pattern, input int cycles);
    for (int i = 0; i < cycles; i++)
    begin
      @(posedge clk);
      events <= pattern;
    end
    @(posedge clk);
    events <= 8'h00;
  endtask
endmodule

/* File: perf_event_qualifier_test.sv */
`timescale 1ns/1ns
`include "perf_event_qualifier_params.svh"

module perf_event_qualifier_test;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wvalid = 1'b0;
  logic [3:0]  wstrb = 4'hF;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ovf;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  ev;
  int          num_errors = 0;
  int          check_count = 0;

  initial forever #25 clk = ~clk;

  perf_event_qualifier dut (
    .CLK_SYS (clk), .ARST_N (arst_n),
    .AWADDR (awaddr), .AWVALID (awvalid), .AWREADY (awready),
    .WDATA (wdata), .WSTRB (wstrb), .WVALID (wvalid), .WREADY (wready),
    .BRESP (bresp), .BVALID (bvalid), .BREADY (bready),
    .ARADDR (araddr), .ARVALID (arvalid), .ARREADY (arready),
    .RDATA (rdata), .RRESP (rresp), .RVALID (rvalid), .RREADY (rready),
    .NOT_STOPPED (ev[0]), .DELIVERY_SWITCH (ev[1]), .SRC_BUILD_MODE (ev[2]),
    .SRC_DELIVER_MODE (ev[3]), .SRC_ROM (ev[4]), .STORE_BUF_EXHAUSTED (ev[5]),
    .EVICT_ANY (ev[6]), .EVICT_NO_FREE (ev[7]), .OVERFLOW_FLAG (ovf)
  );

  event_source_model src (
    .clk    (clk),
    .events (ev)
  );

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    num_errors++;
    close_out();
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 40)
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        return;
      end
    end
    hang();
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 40)
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
        return;
      end
    end
    hang();
  endtask

  // selects, runs the sources, stops the counter, then reads it back
  task automatic run_event(input logic [6:0] sel, input logic [2:0] grp, input logic [15:0] mask,
                           input logic en, input logic edg, input logic [7:0] pat,
                           input int cycles, input logic [31:0] exp);
    axi_write(`OFS_EVSEL, {sel, mask, 9'h000}, `RESP_OKAY);
    axi_write(`OFS_COUNT, 32'h0000_0000, `RESP_OKAY);
    axi_write(`OFS_CFG, {7'h00, edg, 8'h00, grp, en, 12'h000}, `RESP_OKAY);
    src.emit(pat, cycles);
    repeat (2) @(posedge clk);
    axi_write(`OFS_CFG, 32'h0000_0000, `RESP_OKAY);
    axi_read(`OFS_COUNT, exp, `RESP_OKAY);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset_and_map();
    axi_read(`OFS_EVSEL, 32'h0000_0000, `RESP_OKAY);
    axi_read(`OFS_CFG, 32'h0000_0000, `RESP_OKAY);
    axi_read(`OFS_STATUS, 32'h0000_0002, `RESP_OKAY);
    axi_write(8'h10, 32'hFFFF_FFFF, `RESP_SLVERR);
    axi_read(8'h10, 32'h0000_0000, `RESP_SLVERR);
    // only the enabled byte lane may land
    wstrb <= 4'h1;
    axi_write(`OFS_EVSEL, 32'hFFFF_FFFF, `RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(`OFS_EVSEL, 32'h0000_00FF, `RESP_OKAY);
  endtask

  task automatic s_power_and_switch();
    run_event(7'h05, 3'h6, 16'h0001, 1'b1, 1'b0, 8'h01, 5, 32'h5);
    run_event(7'h05, 3'h6, 16'h0000, 1'b1, 1'b0, 8'h01, 5, 32'h0);
    run_event(7'h05, 3'h6, 16'h0001, 1'b0, 1'b0, 8'h01, 5, 32'h0);
    run_event(7'h05, 3'h0, 16'h0001, 1'b1, 1'b0, 8'h03, 4, 32'h4);
  endtask

  task automatic s_queue_writes();
    run_event(7'h09, 3'h0, 16'h0007, 1'b1, 1'b0, 8'h1C, 3, 32'h9);
    run_event(7'h09, 3'h0, 16'h0002, 1'b1, 1'b0, 8'h1C, 3, 32'h3);
    run_event(7'h09, 3'h0, 16'h0005, 1'b1, 1'b0, 8'h08, 3, 32'h0);
  endtask

  task automatic s_stall();
    run_event(7'h01, 3'h1, 16'h0020, 1'b1, 1'b0, 8'h20, 6, 32'h6);
    run_event(7'h01, 3'h1, 16'h0020, 1'b1, 1'b1, 8'h20, 6, 32'h1);
    run_event(7'h01, 3'h1, 16'h0010, 1'b1, 1'b0, 8'h20, 6, 32'h0);
  endtask

  task automatic s_combine();
    run_event(7'h05, 3'h5, 16'h0001, 1'b1, 1'b0, 8'h40, 3, 32'h3);
    run_event(7'h05, 3'h5, 16'h0002, 1'b1, 1'b0, 8'h40, 3, 32'h0);
    run_event(7'h05, 3'h5, 16'h0002, 1'b1, 1'b0, 8'hC0, 3, 32'h3);
    run_event(7'h05, 3'h5, 16'h0003, 1'b1, 1'b0, 8'hC0, 3, 32'h3);
  endtask

  // wrap sets the sticky flag, a write of one clears it
  task automatic s_overflow();
    axi_write(`OFS_EVSEL, {`SEL_POWER, 16'h0001, 9'h000}, `RESP_OKAY);
    axi_write(`OFS_COUNT, 32'hFFFF_FFFF, `RESP_OKAY);
    axi_write(`OFS_CFG, {16'h0000, `GRP_POWER, 13'h1000}, `RESP_OKAY);
    src.emit(8'h01, 2);
    repeat (2) @(posedge clk);
    axi_write(`OFS_CFG, 32'h0000_0000, `RESP_OKAY);
    axi_read(`OFS_COUNT, 32'h0000_0001, `RESP_OKAY);
    axi_read(`OFS_STATUS, 32'h0000_0003, `RESP_OKAY);
    check({31'h0, ovf}, 32'h1);
    axi_write(`OFS_STATUS, 32'h0000_0001, `RESP_OKAY);
    check({31'h0, ovf}, 32'h0);
    // status shows a qualified hit while the source stands
    axi_write(`OFS_CFG, {16'h0000, `GRP_POWER, 13'h1000}, `RESP_OKAY);
    fork
      src.emit(8'h01, 12);
      begin
        repeat (3) @(posedge clk);
        axi_read(`OFS_STATUS, 32'h0000_0006, `RESP_OKAY);
      end
    join
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    s_reset_and_map();
    s_power_and_switch();
    s_queue_writes();
    s_stall();
    s_combine();
    s_overflow();
    close_out();
  end
endmodule
